/* File: src/emb_block.sv */
`timescale 1ns/10ps
module emb_block #(
	parameter int ADDR_W = emb_pkg::EMB_ADDR_W,
	parameter int DATA_W = emb_pkg::EMB_DATA_W
) (
	// clocks and resets
	input wire logic ref_clk,
	input wire logic out_clk,
	input wire logic srst,
	input wire logic chip_clr,
	input wire logic glob_clr,
	// configuration
	input wire emb_pkg::emb_mode_e mode,
	// input side
	input wire logic in_ce,
	input wire logic in_clr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [ADDR_W-1:0] rd_addr,
	input wire logic [DATA_W-1:0] wr_data,
	// output side, plus the input side clash flag
	input wire logic out_ce,
	input wire logic out_clr,
	output logic [DATA_W-1:0] rd_data_r,
	output logic conflict_r
);
	import emb_pkg::*;

	// ****************************************
	// clear trees
	// ****************************************
	logic in_aclr;
	logic out_aclr;

	assign in_aclr = in_clr | glob_clr | chip_clr;
	assign out_aclr = out_clr | glob_clr | chip_clr;

	// ****************************************
	// input registers
	// ****************************************
	logic we_r;
	logic re_r;
	logic [ADDR_W-1:0] wr_addr_r;
	logic [ADDR_W-1:0] rd_addr_r;
	logic [DATA_W-1:0] wr_data_r;
	logic we_nxt;
	logic re_nxt;
	logic [ADDR_W-1:0] rd_addr_nxt;
	logic clash;

	always_comb begin
		clash = (mode == EMB_SINGLE) && wr_en && rd_en;
		we_nxt = wr_en && (mode != EMB_ROM);
		re_nxt = rd_en && !clash;
		rd_addr_nxt = (mode == EMB_SINGLE) ? wr_addr : rd_addr;
	end

	always_ff @(posedge ref_clk or posedge in_aclr) begin
		if (in_aclr) begin
			we_r <= 1'h0;
			re_r <= 1'h0;
			wr_addr_r <= '0;
			rd_addr_r <= '0;
			wr_data_r <= '0;
		end else if (srst) begin
			we_r <= 1'h0;
			re_r <= 1'h0;
			wr_addr_r <= '0;
			rd_addr_r <= '0;
			wr_data_r <= '0;
		end else if (in_ce) begin
			we_r <= we_nxt;
			re_r <= re_nxt;
			wr_addr_r <= wr_addr;
			rd_addr_r <= rd_addr_nxt;
			wr_data_r <= wr_data;
		end
	end

	always_ff @(posedge ref_clk or posedge in_aclr) begin
		if (in_aclr) begin
			conflict_r <= EMB_FLAG_RST;
		end else if (srst) begin
			conflict_r <= EMB_FLAG_RST;
		end else if (in_ce) begin
			conflict_r <= clash;
		end
	end

	// ****************************************
	// storage
	// ****************************************
	logic [DATA_W-1:0] mem_rd;
	logic rom_sel;

	assign rom_sel = (mode == EMB_ROM);

	emb_mem_array #(
		.ADDR_W(ADDR_W),
		.DATA_W(DATA_W)
	) u_emb_mem_array (
		.clk(ref_clk),
		.wr_en(we_r),
		.wr_addr(wr_addr_r),
		.wr_data(wr_data_r),
		.rom_sel(rom_sel),
		.rd_addr(rd_addr_r),
		.rd_data(mem_rd)
	);

	// ****************************************
	// output registers on the output clock
	// ****************************************
	always_ff @(posedge out_clk or posedge out_aclr) begin
		if (out_aclr) begin
			rd_data_r <= '0;
		end else if (out_ce && re_r) begin
			rd_data_r <= mem_rd;
		end
	end

	// ****************************************
	// checks, input side
	// ****************************************
	a_input_capture: assert property (
		@(posedge ref_clk) disable iff (srst || in_aclr)
		in_ce && wr_en && mode == EMB_SPLIT |=> we_r && wr_addr_r == $past(wr_addr)
			&& wr_data_r == $past(wr_data)
	) else $error("input registers missed a write");

	a_input_hold: assert property (
		@(posedge ref_clk) disable iff (srst || in_aclr)
		!in_ce |=> $stable(rd_addr_r) && $stable(we_r) && $stable(re_r)
	) else $error("input registers moved without enable");

	a_single_excl: assert property (
		@(posedge ref_clk) disable iff (srst || in_aclr)
		in_ce && mode == EMB_SINGLE && wr_en && rd_en |=> !re_r && we_r && conflict_r
	) else $error("single port clash not handled");

	a_rom_no_write: assert property (
		@(posedge ref_clk) disable iff (srst || in_aclr)
		in_ce && mode == EMB_ROM |=> !we_r
	) else $error("write reached rom");

	a_input_clear: assert property (
		@(posedge ref_clk)
		in_aclr |-> !we_r && !re_r && rd_addr_r == '0 && !conflict_r
	) else $error("input side not cleared");

	// ****************************************
	// checks, output side, plus the input side single port clash cover
	// ****************************************
	a_output_hold: assert property (
		@(posedge out_clk) disable iff (out_aclr)
		!(out_ce && re_r) |=> $stable(rd_data_r)
	) else $error("read data moved without enable");

	a_output_update: assert property (
		@(posedge out_clk) disable iff (out_aclr)
		out_ce && re_r |=> rd_data_r == $past(mem_rd)
	) else $error("read data not loaded on output edge");

	a_output_clear: assert property (
		@(posedge out_clk)
		out_aclr |-> rd_data_r == '0
	) else $error("output side not cleared");

	c_split_read: cover property (
		@(posedge out_clk) disable iff (out_aclr)
		mode == EMB_SPLIT && out_ce && re_r
	);

	c_single_clash: cover property (
		@(posedge ref_clk) disable iff (srst || in_aclr)
		in_ce && mode == EMB_SINGLE && wr_en && rd_en
	);

	c_rom_read: cover property (
		@(posedge out_clk) disable iff (out_aclr)
		mode == EMB_ROM && out_ce && re_r
	);

	// ****************************************
	// checks, address capture and gating
	// ****************************************
	a_read_capture: assert property (
		@(posedge ref_clk) disable iff (srst || in_aclr)
		in_ce && rd_en && mode != EMB_SINGLE |=> re_r && rd_addr_r == $past(rd_addr)
	) else $error("input registers missed a read");

	a_single_addr: assert property (
		@(posedge ref_clk) disable iff (srst || in_aclr)
		in_ce && mode == EMB_SINGLE && rd_en && !wr_en |=> re_r && rd_addr_r == $past(wr_addr)
	) else $error("single port read used wrong address");

	a_conflict_pulse: assert property (
		@(posedge ref_clk) disable iff (srst || in_aclr)
		in_ce && !(mode == EMB_SINGLE && wr_en && rd_en) |=> !conflict_r
	) else $error("clash flag raised without a clash");

	a_ce_write_gate: assert property (
		@(posedge ref_clk) disable iff (srst || in_aclr)
		!in_ce |=> $stable(wr_addr_r) && $stable(wr_data_r) && $stable(conflict_r)
	) else $error("write side moved without enable");

	c_input_gated: cover property (
		@(posedge ref_clk) disable iff (srst || in_aclr)
		!in_ce && wr_en
	);

	c_input_cleared: cover property (
		@(posedge ref_clk)
		in_clr
	);

endmodule

/* File: inc/emb_pkg.sv */
package emb_pkg;

	// ****************************************
	// geometry and reset values
	// ****************************************
	localparam int EMB_ADDR_W = 8;
	localparam int EMB_DATA_W = 16;
	localparam logic EMB_FLAG_RST = 1'h0;

	// ****************************************
	// operating modes
	// ****************************************
	typedef enum logic [1:0] {
		EMB_SPLIT,
		EMB_SINGLE,
		EMB_ROM
	} emb_mode_e;

	// ****************************************
	// configuration-time lookup pattern
	// ****************************************
	localparam logic [31:0] EMB_ROM_MUL = 32'h9e37_79b1;
	localparam logic [31:0] EMB_ROM_XOR = 32'h5a5a_c3c3;

	function automatic logic [31:0] emb_rom_word(input logic [31:0] addr);
		logic [31:0] prod;
		prod = 32'h0;
		prod = addr * EMB_ROM_MUL;
		return prod ^ EMB_ROM_XOR;
	endfunction

endpackage

/* File: src/emb_mem_array.sv */
`timescale 1ns/10ps
module emb_mem_array #(
	parameter int ADDR_W = emb_pkg::EMB_ADDR_W,
	parameter int DATA_W = emb_pkg::EMB_DATA_W
) (
	// clock
	input wire logic clk,
	// write port
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	// read port
	input wire logic rom_sel,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data
);
	import emb_pkg::*;

	localparam int DEPTH = 1 << ADDR_W;

	logic [DATA_W-1:0] mem_r [DEPTH];
	logic [31:0] rom_word;

	// ****************************************
	// storage, written on the input clock
	// ****************************************
	always_ff @(posedge clk) begin
		if (wr_en && !rom_sel) begin
			mem_r[wr_addr] <= wr_data;
		end
	end

	// ****************************************
	// read mux: ram or configured pattern
	// ****************************************
	always_comb begin
		rom_word = emb_rom_word(32'(rd_addr));
		if (rom_sel) begin
			rd_data = rom_word[DATA_W-1:0];
		end else begin
			rd_data = mem_r[rd_addr];
		end
	end

endmodule

/* File: testbench/emb_fabric.sv */
`timescale 1ns/10ps
// ****
// fabric user logic
// ****
module emb_fabric (
	// requests from bench
	input wire logic req_wr,
	input wire logic req_rd,
	input wire logic clash_ok,
	input wire emb_pkg::emb_mode_e mode,
	// block side
	output logic wr_en,
	output logic rd_en
);
	import emb_pkg::*;
	assign wr_en = req_wr;
	assign rd_en = req_rd & (clash_ok | mode != EMB_SINGLE | ~req_wr);
endmodule

/* File: testbench/test_embedded_memory_block_modes.sv */
`timescale 1ns/10ps
module test_embedded_memory_block_modes;
	import emb_pkg::*;
	// ****
	// stimulus and checks
	// ****
	logic ref_clk = 0, srst = 1, chip_clr = 0, in_ce = 1, in_clr = 0, out_ce = 1, out_clr = 0;
	logic req_wr = 0, req_rd = 0, clash_ok = 0, wr_en, rd_en, conflict_r, p1 = 0, p2 = 0;
	logic [EMB_ADDR_W-1:0] a = 0;
	logic [EMB_ADDR_W-1:0] al [8];
	logic [EMB_DATA_W-1:0] d = 0, rd_data_r;
	logic [EMB_DATA_W-1:0] mem [logic [EMB_ADDR_W-1:0]];
	logic [EMB_DATA_W-1:0] exp_q [$];
	logic [31:0] seed = 32'd59144, t;
	int err_total = 0, total_checks = 0, cyc = 0, hits;
	emb_mode_e mode = EMB_SPLIT;
	emb_fabric u_emb_fabric (.req_wr(req_wr), .req_rd(req_rd), .clash_ok(clash_ok), .mode(mode),
		.wr_en(wr_en), .rd_en(rd_en));
	emb_block u_emb_block (.ref_clk(ref_clk), .out_clk(ref_clk), .srst(srst), .chip_clr(chip_clr),
		.glob_clr(chip_clr), .mode(mode), .in_ce(in_ce), .in_clr(in_clr), .wr_en(wr_en),
		.rd_en(rd_en), .wr_addr(a), .rd_addr(a), .wr_data(d), .out_ce(out_ce),
		.out_clr(out_clr), .rd_data_r(rd_data_r), .conflict_r(conflict_r));
	initial forever #20 ref_clk = ~ref_clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] want);
		total_checks++;
		if (got !== want) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic op(input logic w, input logic r, input logic [7:0] ad, input logic [15:0] dd);
		@(negedge ref_clk);
		req_wr = w;
		req_rd = r;
		a = ad;
		d = dd;
		t = {24'h0, ad} * EMB_ROM_MUL ^ EMB_ROM_XOR;
		if (r && in_ce && !(mode == EMB_SINGLE && w))
			exp_q.push_back(mode == EMB_ROM ? t[15:0] : mem[ad]);
		if (w && in_ce && mode != EMB_ROM)
			mem[ad] = dd;
	endtask
	task automatic conclude();
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		p1 <= rd_en & in_ce & ~srst & ~(mode == EMB_SINGLE & wr_en);
		p2 <= p1 & out_ce;
		if (cyc > 3000) begin
			err_total++;
			conclude();
		end
	end
	always @(negedge ref_clk) if (p2) check(rd_data_r, exp_q.pop_front());
	initial begin
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk) srst = 0;
		for (int m = 0; m < 3; m++) begin
			mode = emb_mode_e'(m);
			for (int i = 0; i < 8; i++) begin
				seed = xs(seed);
				al[i] = {seed[7:3], 3'(i)};
				op(1, 0, al[i], seed[23:8]);
			end
			for (int i = 0; i < 8; i++) op(0, 1, al[i], 0);
			op(0, 0, 0, 0);
			repeat (3) @(negedge ref_clk);
		end
		mode = EMB_SINGLE;
		clash_ok = 1;
		op(1, 1, 8'h05, 16'hbeef);
		op(0, 0, 0, 0);
		hits = int'(conflict_r);
		repeat (3) @(negedge ref_clk) hits += int'(conflict_r);
		check(16'(hits), 16'h1);
		op(1, 1, 8'h05, 16'hbeef);
		op(0, 0, 0, 0);
		clash_ok = 0;
		check(16'(conflict_r), 16'h1);
		in_clr = 1;
		#1 check(16'(conflict_r), 16'h0);
		@(negedge ref_clk) in_clr = 0;
		mode = EMB_SPLIT;
		in_ce = 0;
		op(1, 0, 8'h05, 16'h1234);
		op(0, 0, 0, 0);
		in_ce = 1;
		op(0, 1, 8'h05, 0);
		op(0, 0, 0, 0);
		repeat (4) @(negedge ref_clk);
		out_clr = 1;
		#1 check(rd_data_r, 16'h0);
		@(negedge ref_clk) out_clr = 0;
		op(0, 1, 8'h05, 0);
		op(0, 0, 0, 0);
		repeat (4) @(negedge ref_clk);
		chip_clr = 1;
		#1 check(rd_data_r, 16'h0);
		@(negedge ref_clk) chip_clr = 0;
		check(16'(exp_q.size()), 16'h0);
		conclude();
	end
endmodule
